// [rtl/processor_trace_port.sv]
// Behaviour
// - Fresh status published once per four-cycle period
// - Period strobe rises at each period start
// - Three-bit branch status per trace period
// - Five-bit execution status updated with strobe
// - Seven-bit trace status for flow rebuild
// - Trigger output summarises enabled debug events
// - Fourteen-bit bus names the causing event
// - Event bits: compares, trap, interrupt, debug, return
// - Trigger input inserts code in low bits
// - Internal trigger code aligns with current broadcast
// - External trigger code joins current instruction
// - Trace disable input suppresses strobe and status outputs
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "trace_port_defs.svh"

module processor_trace_port #(
  parameter int KIND_W = 14
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire trace_port_pkg::core_trace_t core_trace_in,
  input wire logic [KIND_W-1:0] debug_event_in,
  input wire logic trigger_event_in,
  input wire logic trace_off_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic trace_period_strobe_out,
  output logic [2:0] branch_status_out,
  output logic [4:0] exec_status_out,
  output logic [6:0] trace_status_out,
  output logic trigger_event_out,
  output logic [KIND_W-1:0] trigger_event_kind_out,
  output logic irq_out
);

  // ========================================================================
  // Elaboration checks
  // ========================================================================
  // The event map needs twelve defined bits and the info register has room
  // for sixteen.
  if (KIND_W < 12 || KIND_W > 16)
  begin : g_kind_w_check
    $error("KIND_W must lie between 12 and 16");
  end

  // The phase register walks exactly four one-hot states, so any other
  // period length would need a different divider.
  if (`TP_PERIOD_CYCLES != 4)
  begin : g_period_check
    $error("The trace period must span four cycles");
  end

  // ========================================================================
  // Declarations
  // ========================================================================
  trace_port_pkg::phase_t phase;
  trace_port_pkg::phase_t next_phase;
  logic ctrl_en;
  logic [KIND_W-1:0] trig_en;
  logic [`TP_ST_W-1:0] status;
  logic [`TP_ST_W-1:0] mask;
  logic [`TP_ST_W-1:0] next_status;
  logic [`TP_ST_W-1:0] status_set;
  logic [`TP_ST_W-1:0] status_clr;
  logic trig_pend;
  logic live;
  logic period_end;
  logic trig_now;
  logic [KIND_W-1:0] kind_hit;
  logic wr_ctrl;
  logic wr_trig_en;
  logic wr_status;
  logic wr_mask;
  logic [31:0] next_rdata;
  logic [6:0] next_trace_status;
  logic next_strobe;

  // ========================================================================
  // Period divider
  // ========================================================================
  // The phase walks PH_0..PH_3 and the broadcast happens on the edge that
  // leaves PH_3, so the new words are visible throughout PH_0..PH_3.
  always_comb
  begin
    case (phase)
      trace_port_pkg::PH_0: next_phase = trace_port_pkg::PH_1;
      trace_port_pkg::PH_1: next_phase = trace_port_pkg::PH_2;
      trace_port_pkg::PH_2: next_phase = trace_port_pkg::PH_3;
      trace_port_pkg::PH_3: next_phase = trace_port_pkg::PH_0;
      default: next_phase = trace_port_pkg::PH_0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase <= trace_port_pkg::PH_0;
    end
    else
    begin
      phase <= next_phase;
    end
  end

  assign period_end = (phase == trace_port_pkg::PH_3);
  assign live = ctrl_en && !trace_off_in;

  // ========================================================================
  // Trigger capture
  // ========================================================================
  // A trigger seen anywhere in the period is held and folded into the next
  // broadcast, which also forgives a return path of up to three cycles.
  assign trig_now = trig_pend || trigger_event_in;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trig_pend <= 1'b0;
    end
    else if (period_end)
    begin
      trig_pend <= 1'b0;
    end
    else if (trigger_event_in)
    begin
      trig_pend <= 1'b1;
    end
  end

  always_comb
  begin
    next_trace_status = core_trace_in.trace_status_field;
    if (trig_now)
    begin
      next_trace_status[3:0] = `TP_TRIG_CODE;
    end
  end

  // ========================================================================
  // Trace broadcast
  // ========================================================================
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      exec_status_out <= `TP_IDLE_EXEC;
      branch_status_out <= `TP_IDLE_BRANCH;
      trace_status_out <= `TP_IDLE_TRACE;
    end
    else if (!live)
    begin
      exec_status_out <= `TP_IDLE_EXEC;
      branch_status_out <= `TP_IDLE_BRANCH;
      trace_status_out <= `TP_IDLE_TRACE;
    end
    else if (period_end)
    begin
      exec_status_out <= core_trace_in.exec_status;
      branch_status_out <= core_trace_in.branch_status;
      trace_status_out <= next_trace_status;
    end
  end

  // The strobe is high for the first half of each period so that its rising
  // edge marks the start; it is a data signal, not a clock.
  // It stays high in PH_0 only when it was raised at the boundary, so a reset
  // release or a late enable never shows a rise that no broadcast goes with.
  always_comb
  begin
    next_strobe = 1'b0;
    if (live && period_end)
    begin
      next_strobe = 1'b1;
    end
    else if (live && phase == trace_port_pkg::PH_0)
    begin
      next_strobe = trace_period_strobe_out;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trace_period_strobe_out <= 1'b0;
    end
    else
    begin
      trace_period_strobe_out <= next_strobe;
    end
  end

  // ========================================================================
  // Debug trigger events
  // ========================================================================
  // Bit order of debug_event_in follows the event map, so enabling and
  // reporting stay a plain per-bit mask.
  // Spare bits above the defined events pass through the same mask, so a
  // core with more events can report them without touching this logic.
  for (genvar b = 0; b < KIND_W; b++)
  begin : g_kind_bit
    assign kind_hit[b] = debug_event_in[b] && trig_en[b];
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trigger_event_out <= 1'b0;
      trigger_event_kind_out <= '0;
    end
    else
    begin
      trigger_event_out <= |kind_hit;
      trigger_event_kind_out <= kind_hit;
    end
  end

  // ========================================================================
  // Register port
  // ========================================================================
  // Writes to unmapped offsets are dropped and reads of them return zero.
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `TP_OFF_CTRL);
  assign wr_trig_en = reg_wr_in && (reg_addr_in == `TP_OFF_TRIG_EN);
  assign wr_status = reg_wr_in && (reg_addr_in == `TP_OFF_STATUS);
  assign wr_mask = reg_wr_in && (reg_addr_in == `TP_OFF_MASK);

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_en <= `TP_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_en <= reg_wdata_in[`TP_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trig_en <= KIND_W'(`TP_TRIG_EN_RST);
    end
    else if (wr_trig_en)
    begin
      trig_en <= reg_wdata_in[KIND_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask <= `TP_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask <= reg_wdata_in[`TP_ST_W-1:0];
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_in)
      `TP_OFF_CTRL: next_rdata[`TP_CTRL_EN_BIT] = ctrl_en;
      `TP_OFF_TRIG_EN: next_rdata[KIND_W-1:0] = trig_en;
      `TP_OFF_STATUS: next_rdata[`TP_ST_W-1:0] = status;
      `TP_OFF_MASK: next_rdata[`TP_ST_W-1:0] = mask;
      `TP_OFF_INFO:
      begin
        next_rdata[`TP_INFO_PHASE_LSB +: 4] = phase;
        next_rdata[`TP_INFO_PEND_BIT] = trig_pend;
        next_rdata[`TP_INFO_KIND_LSB +: KIND_W] = trigger_event_kind_out;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe and read zero
  // otherwise, which keeps stale data off the bus.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
    end
    else if (reg_rd_in)
    begin
      reg_rdata_out <= next_rdata;
    end
    else
    begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ========================================================================
  // Interrupt status
  // ========================================================================
  always_comb
  begin
    status_set = '0;
    status_set[`TP_ST_TRIG_IN_BIT] = trigger_event_in;
    status_set[`TP_ST_DBG_EVT_BIT] = |kind_hit;
    // The trace-off bit is set again in every cycle that the input stays high,
    // so a clear only sticks once the input has fallen.
    status_set[`TP_ST_OFF_BIT] = trace_off_in;
    status_clr = wr_status ? reg_wdata_in[`TP_ST_W-1:0] : '0;
    // A new event in the clearing cycle survives the clear.
    next_status = (status & ~status_clr) | status_set;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status <= '0;
    end
    else
    begin
      status <= next_status;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(next_status & mask);
    end
  end

endmodule // processor_trace_port

// [rtl/trace_port_defs.svh]
`ifndef TRACE_PORT_DEFS_SVH
`define TRACE_PORT_DEFS_SVH

// ==========================================================================
// Trace period
// ==========================================================================
`define TP_PERIOD_CYCLES 4

// ==========================================================================
// Register offsets (byte addresses)
// ==========================================================================
`define TP_OFF_CTRL 8'h00
`define TP_OFF_TRIG_EN 8'h04
`define TP_OFF_STATUS 8'h08
`define TP_OFF_MASK 8'h0c
`define TP_OFF_INFO 8'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define TP_CTRL_EN_BIT 0
`define TP_ST_TRIG_IN_BIT 0
`define TP_ST_DBG_EVT_BIT 1
`define TP_ST_OFF_BIT 2
`define TP_ST_W 3
`define TP_INFO_PHASE_LSB 0
`define TP_INFO_PEND_BIT 4
`define TP_INFO_KIND_LSB 16

// ==========================================================================
// Event-type bit positions
// ==========================================================================
`define TP_KIND_INSN_ADDR_MATCH_1 0
`define TP_KIND_DATA_ADDR_MATCH_1_READ 4
`define TP_KIND_TRAP 8
`define TP_KIND_INTERRUPT_EVENT 9
`define TP_KIND_UNCOND_DEBUG_EVENT 10
`define TP_KIND_RETURN_EVENT 11

// ==========================================================================
// Reset values and codes
// ==========================================================================
`define TP_CTRL_RST 1'b1
`define TP_TRIG_EN_RST 16'hffff
`define TP_MASK_RST 3'h0
`define TP_TRIG_CODE 4'h1
`define TP_IDLE_EXEC 5'h00
`define TP_IDLE_BRANCH 3'h0
`define TP_IDLE_TRACE 7'h00

`endif

// [rtl/trace_port_pkg.sv]
package trace_port_pkg;

  // ========================================================================
  // Status words handed over by the core pipeline each cycle
  // ========================================================================
  typedef struct packed {
    logic [4:0] exec_status;
    logic [2:0] branch_status;
    logic [6:0] trace_status_field;
  } core_trace_t;

  // ========================================================================
  // Position within the four-cycle trace period
  // ========================================================================
  typedef enum logic [3:0] {
    PH_0 = 4'b0001,
    PH_1 = 4'b0010,
    PH_2 = 4'b0100,
    PH_3 = 4'b1000
  } phase_t;

endpackage

// [test/processor_trace_port_assertions.sv]
`timescale 1ns/1ps
// ====================
// Broadcast cadence and trigger checks.
module processor_trace_port_assertions #(
  parameter int KIND_W = 14
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire trace_port_pkg::core_trace_t core_trace_in,
  input wire logic [KIND_W-1:0] debug_event_in,
  input wire logic trigger_event_in,
  input wire logic trace_off_in,
  input wire logic trace_period_strobe_out,
  input wire logic [2:0] branch_status_out,
  input wire logic [4:0] exec_status_out,
  input wire logic [6:0] trace_status_out,
  input wire logic trigger_event_out,
  input wire logic [KIND_W-1:0] trigger_event_kind_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence bcast;
    $rose(trace_period_strobe_out);
  endsequence
  sequence rest_of_period;
    trace_period_strobe_out ##1 (!trace_period_strobe_out) [*2] ##1 bcast;
  endsequence
  // A disabled trace breaks the cadence legally, so the cycle check stands down.
  a_strobe_cycle: assert property (disable iff (!rst_n_in || trace_off_in)
    bcast |=> rest_of_period) else $error("strobe cadence broken");
  a_data_hold: assert property (
    !$stable({exec_status_out, branch_status_out, trace_status_out})
      |-> $rose(trace_period_strobe_out) || $past(trace_off_in))
    else $error("trace data changed inside a period");
  a_word_load: assert property (
    bcast |-> {exec_status_out, branch_status_out, trace_status_out[6:4]}
      == $past({core_trace_in.exec_status, core_trace_in.branch_status,
        core_trace_in.trace_status_field[6:4]})) else $error("wrong word broadcast");
  a_trig_code: assert property (
    bcast ##0 $past(trigger_event_in) |-> trace_status_out[3:0] == 4'h1)
    else $error("trigger code missing");
  a_no_trig: assert property (
    bcast ##0 !(|{$past(trigger_event_in), $past(trigger_event_in, 2),
      $past(trigger_event_in, 3), $past(trigger_event_in, 4)})
      |-> trace_status_out[3:0] == $past(core_trace_in.trace_status_field[3:0]))
    else $error("trace status low bits altered");
  a_trig_summary: assert property (
    trigger_event_out == (|trigger_event_kind_out)) else $error("summary mismatch");
  a_kind_cause: assert property (
    (trigger_event_kind_out & ~$past(debug_event_in)) == '0) else $error("kind without event");
  a_off_quiet: assert property (
    trace_off_in |=> !trace_period_strobe_out
      && {exec_status_out, branch_status_out, trace_status_out} == '0)
    else $error("trace output while disabled");
endmodule // processor_trace_port_assertions

bind processor_trace_port processor_trace_port_assertions #(.KIND_W(KIND_W)) chk_i (
  .core_clk_in, .rst_n_in, .core_trace_in, .debug_event_in, .trigger_event_in,
  .trace_off_in, .trace_period_strobe_out, .branch_status_out, .exec_status_out,
  .trace_status_out, .trigger_event_out, .trigger_event_kind_out);

// [test/test_processor_trace_port.sv]
`timescale 1ns/1ps
`include "trace_port_defs.svh"
`define CHK(nm, ex, got) \
  begin total_checks++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
// ====================
// Random periods with corner cases, registers, trace off and interrupt.
module test_processor_trace_port;
  logic core_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  trace_port_pkg::core_trace_t core_trace_in = 15'h0;
  logic [13:0] debug_event_in = 14'h0;
  logic trace_off_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic [1:0] mode = 2'h0;
  logic ext = 1'h0;
  logic [13:0] trig_en = 14'h3fff;
  logic trigger_event_in, trace_period_strobe_out, trigger_event_out, irq_out;
  logic [31:0] reg_rdata_out;
  logic [2:0] branch_status_out;
  logic [4:0] exec_status_out;
  logic [6:0] trace_status_out;
  logic [13:0] trigger_event_kind_out;
  logic [15:0] trace_word;
  assign trace_word = {trace_period_strobe_out, exec_status_out, branch_status_out,
    trace_status_out};
  int failures = 0;
  int total_checks = 0;
  processor_trace_port #(.KIND_W(14)) processor_trace_port_i (.core_clk_in, .rst_n_in,
    .core_trace_in, .debug_event_in, .trigger_event_in, .trace_off_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .trace_period_strobe_out,
    .branch_status_out, .exec_status_out, .trace_status_out, .trigger_event_out,
    .trigger_event_kind_out, .irq_out);
  trace_tool_model trace_tool_model_i (.core_clk_in, .mode_in(mode), .ext_in(ext),
    .trig_from_core_in(trigger_event_out), .trig_to_core_out(trigger_event_in));
  initial
  begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'h0;
    #1;
    `CHK("reg_rdata", ex & m, reg_rdata_out & m)
  endtask
  task automatic irq_is(input logic ex);
    @(posedge core_clk_in);
    #1;
    `CHK("irq", ex, irq_out)
  endtask
  task automatic wait_rise;
    logic was;
    was = 1'h1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge core_clk_in);
      #1;
      if (trace_period_strobe_out === 1'h1 && !was)
        return;
      was = trace_period_strobe_out;
    end
    $display("[ERR] strobe rise expected 1 seen 0");
    failures++;
    complete_run;
  endtask
  // Called one step after a period boundary; ends one step after the next one.
  task automatic period(input trace_port_pkg::core_trace_t w, input logic [13:0] dbg,
    input logic [1:0] md, input logic e);
    logic [6:0] ts;
    ts = w.trace_status_field;
    if (md == 2'h2 ? e : |(dbg & trig_en))
      ts[3:0] = `TP_TRIG_CODE;
    for (int k = 1; k < 5; k++)
    begin
      @(posedge core_clk_in);
      if (k == 1)
      begin
        core_trace_in <= w;
        debug_event_in <= dbg;
        mode <= md;
        ext <= e;
      end
      if (k == 2)
      begin
        debug_event_in <= 14'h0;
        ext <= 1'h0;
      end
      #1;
      `CHK("strobe", k == 1 || k == 4, trace_period_strobe_out)
      if (k == 2)
      begin
        `CHK("kind", dbg & trig_en, trigger_event_kind_out)
        `CHK("trig_out", |(dbg & trig_en), trigger_event_out)
      end
    end
    `CHK("exec", w.exec_status, exec_status_out)
    `CHK("branch", w.branch_status, branch_status_out)
    `CHK("trace", ts, trace_status_out)
  endtask
  initial
  begin
    trace_port_pkg::core_trace_t w;
    logic [13:0] dbg;
    void'($urandom(35058));
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'h1;
    @(posedge core_clk_in);
    #1;
    `CHK("idle", 31'h0, {trace_word, trigger_event_out, trigger_event_kind_out})
    reg_read(`TP_OFF_CTRL, 32'h1, 32'hffffffff);
    reg_read(`TP_OFF_TRIG_EN, 32'h3fff, 32'h3fff);
    reg_read(`TP_OFF_MASK, 32'h0, 32'hffffffff);
    reg_read(8'h40, 32'h0, 32'hffffffff);
    wait_rise;
    for (int i = 0; i < 40; i++)
    begin
      if (i == 24)
      begin
        trig_en = 14'($urandom);
        reg_write(`TP_OFF_TRIG_EN, {18'h0, trig_en});
        wait_rise;
      end
      w = 15'($urandom);
      dbg = (i < 12) ? 14'h1 << i : ($urandom % 3 == 0) ? 14'($urandom) : 14'h0;
      period(w, dbg, (i < 12) ? 2'(i % 3) : 2'($urandom % 3), 1'($urandom));
    end
    @(posedge core_clk_in);
    trace_off_in <= 1'h1;
    repeat (6) @(posedge core_clk_in);
    #1;
    `CHK("off", 16'h0, trace_word)
    reg_read(`TP_OFF_STATUS, 32'h4, 32'h4);
    reg_write(`TP_OFF_CTRL, 32'h0);
    @(posedge core_clk_in);
    trace_off_in <= 1'h0;
    repeat (6) @(posedge core_clk_in);
    #1;
    `CHK("ctrl_off", 16'h0, trace_word)
    reg_read(`TP_OFF_CTRL, 32'h0, 32'hffffffff);
    reg_write(`TP_OFF_CTRL, 32'h1);
    trig_en = 14'h3fff;
    reg_write(`TP_OFF_TRIG_EN, 32'h3fff);
    reg_write(`TP_OFF_STATUS, 32'h7);
    reg_write(`TP_OFF_MASK, 32'h2);
    irq_is(1'h0);
    wait_rise;
    period(15'($urandom), 14'h100, 2'h0, 1'h0);
    irq_is(1'h1);
    reg_read(`TP_OFF_STATUS, 32'h2, 32'h2);
    reg_write(`TP_OFF_MASK, 32'h0);
    irq_is(1'h0);
    reg_write(`TP_OFF_MASK, 32'h2);
    irq_is(1'h1);
    reg_write(`TP_OFF_STATUS, 32'h2);
    irq_is(1'h0);
    complete_run;
  end
endmodule // test_processor_trace_port

// [test/trace_tool_model.sv]
`timescale 1ns/1ps
// ====================
// Trace tool and user trigger logic on the far side.
module trace_tool_model (
  input wire logic core_clk_in,
  input wire logic [1:0] mode_in,
  input wire logic ext_in,
  input wire logic trig_from_core_in,
  output logic trig_to_core_out
);
  logic late;
  // One flop stands for a relaxed return path; it still lands inside the period.
  always_ff @(posedge core_clk_in)
  begin
    late <= trig_from_core_in;
  end
  always_comb
  begin
    case (mode_in)
      2'h0: trig_to_core_out = trig_from_core_in;
      2'h1: trig_to_core_out = late;
      default: trig_to_core_out = ext_in;
    endcase
  end
endmodule // trace_tool_model
